// file: hw/kps_pkg.sv
// shared types and constants of the knx/modbus point synchroniser
package kps_pkg;
  localparam int NPTS = 8;
  localparam int PIDX_W = 3;
  localparam int NSLV = 254;
  localparam logic [7:0] SLV_MAX = 8'h00_FE;
  // register map, byte addresses
  localparam logic [11:0] CTRL_OFS = 12'h0_000;
  localparam logic [11:0] STAT_OFS = 12'h0_004;
  localparam logic [3:0] PT_PAGE = 4'h1;
  localparam logic [3:0] ERR_PAGE = 4'h2;
  localparam logic [1:0] PT_CFG = 2'h0;
  localparam logic [1:0] PT_GRP = 2'h1;
  localparam logic [1:0] PT_VAL = 2'h2;
  localparam logic [1:0] PT_FLG = 2'h3;
  // telegram kinds
  localparam logic [1:0] TEL_READ = 2'h0;
  localparam logic [1:0] TEL_RESP = 2'h1;
  localparam logic [1:0] TEL_WRITE = 2'h2;

  typedef struct packed {
    logic [7:0] slave;
    logic [3:0] datapointTypeSel;
    logic upd;
    logic tx;
    logic wr;
    logic rd;
    logic active;
  } pt_cfg_t;

  typedef struct packed {
    logic lsbFirst;
    logic rs485;
    logic [1:0] parity;
    logic stop2;
    logic [3:0] dataBits;
    logic [15:0] baudDiv;
  } ser_cfg_t;

  // 9600 baud at 10 MHz, 8 data bits, 1 stop, no parity, point-to-point link, msb first
  localparam ser_cfg_t SER_RST = 25'h08_0411;

  typedef struct packed {
    logic [1:0] kind;
    logic [15:0] group;
    logic [15:0] data;
    logic [3:0] datapointTypeSel;
  } knx_tel_t;

  typedef struct packed {
    logic [7:0] slave;
    logic [PIDX_W-1:0] pidx;
    logic write;
    logic [15:0] data;
  } mb_req_t;

  typedef struct packed {
    logic [15:0] data;
    logic timeout;
  } mb_rsp_t;

  typedef enum logic [1:0] {MB_IDLE, MB_REQ, MB_WAIT} mb_st_t;

  typedef struct packed {
    pt_cfg_t [NPTS-1:0] cfg;
    logic [NPTS-1:0][15:0] grp;
    logic [NPTS-1:0][15:0] lsn;
    logic [NPTS-1:0][15:0] val;
    logic [NPTS-1:0] wrPend;
    logic [NPTS-1:0] rdAns;
    logic [NPTS-1:0] txPend;
    logic [NPTS-1:0] updPend;
    logic [NPTS-1:0] updWait;
    logic [NSLV-1:0] slvErr;
    ser_cfg_t ser;
    logic busOkPrev;
    logic [PIDX_W-1:0] pollIdx;
    mb_st_t mbSt;
    mb_req_t req;
    logic txValid;
    knx_tel_t txTel;
    logic ack;
    logic [31:0] rdat;
  } st_t;
endpackage

// file: hw/kps_sync.sv
// two-flop synchroniser, one lane per bit
`timescale 1ns/100ps
module kps_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : gLane
      logic meta_r;
      logic sync_r;
      // first stage feeds only the second stage
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          meta_r <= 1'b0;
          sync_r <= 1'b0;
        end else if (ce) begin
          meta_r <= din[g];
          sync_r <= meta_r;
        end
      end
      assign dout[g] = sync_r;
    end
  endgenerate
endmodule // kps_sync

// file: hw/kps_swap.sv
// byte order selector for 16-bit register words
`timescale 1ns/100ps
module kps_swap (
  input wire logic lsbFirst,
  input wire logic [15:0] din,
  output logic [15:0] dout
);
  assign dout = lsbFirst ? {din[7:0], din[15:8]} : din;
endmodule // kps_swap

// file: hw/knx_modbus_point_sync.sv
// point synchronisation engine between knx group telegrams and a modbus master
// Functional notes
// - knx telegram triggers matching modbus request
// - field value change sends knx telegram
// - after bus recovery resend transmit points
// - after bus recovery refresh update points
// - answer reads only when read enabled
// - accept writes only when write enabled; writes to a listening address are taken without wr
// - transmit point change sends group write
// - update points read group, forward reply
// - inactive point takes part in nothing
// - listening addresses also act on point
// - one sending group per point
// - datapoint type selector travels with telegrams
// - device is sole serial master
// - up to 254 slave stations
// - rs485 multidrop or rs232 single slave
// - serial parameters configurable and shared
// - 16-bit byte order configurable
// - poll readable points continuously, store values; polling pauses while knx bus health is low
// - slave timeout sets its error status
//
// Design decisions made here: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/100ps
module knx_modbus_point_sync
  import kps_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // classic wishbone slave
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [11:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [31:0] wbDatW,
  output logic [31:0] wbDatR,
  output logic wbAck,
  // knx bus health pin and telegram ports
  input wire logic knxBusOk,
  input wire logic knxRxValid,
  input wire knx_tel_t knxRx,
  output logic knxTxValid,
  input wire logic knxTxReady,
  output knx_tel_t knxTx,
  // modbus master request and answer
  output logic mbReqValid,
  input wire logic mbReqReady,
  output mb_req_t mbReq,
  input wire logic mbRspValid,
  input wire mb_rsp_t mbRsp,
  output ser_cfg_t serCfg
);
  st_t s_r;
  st_t s_nxt;
  logic busOk;
  logic [15:0] rspData;
  logic [15:0] wrValRaw;
  logic [15:0] wrValOut;
  logic [PIDX_W-1:0] wrIdx;
  logic wrAny;
  logic [NPTS-1:0] hitG;
  logic [NPTS-1:0] hitL;

  // bus health comes from a pin, so it is synchronised first
  kps_sync #(.W(1)) uSync (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .din(knxBusOk),
    .dout(busOk)
  );

  // incoming register words are reordered before compare and store
  kps_swap uRspSwap (
    .lsbFirst(s_r.ser.lsbFirst),
    .din(mbRsp.data),
    .dout(rspData)
  );

  kps_swap uReqSwap (
    .lsbFirst(s_r.ser.lsbFirst),
    .din(wrValRaw),
    .dout(wrValOut)
  );

  always_comb begin
    wrAny = 1'b0;
    wrIdx = '0;
    for (int i = NPTS - 1; i >= 0; i--) begin
      if (s_r.wrPend[i] && s_r.cfg[i].active) begin
        wrAny = 1'b1;
        wrIdx = PIDX_W'(i);
      end
    end
    wrValRaw = s_r.val[wrIdx];
  end

  // per-point group match, inactive points never match
  genvar g;
  generate
    for (g = 0; g < NPTS; g++) begin : gHit
      assign hitG[g] = s_r.cfg[g].active && (s_r.grp[g] == knxRx.group);
      assign hitL[g] = s_r.cfg[g].active && (s_r.lsn[g] != 16'h0000)
                       && (s_r.lsn[g] == knxRx.group);
    end
  endgenerate

  function automatic logic [31:0] mrg(input logic [31:0] old, input logic [31:0] wd,
                                      input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // next state of the whole engine
  always_comb begin
    logic found;
    logic [PIDX_W-1:0] pi;
    logic [7:0] sIdx;
    logic [31:0] w;
    logic [31:0] rd;
    found = 1'b0;
    pi = '0;
    sIdx = '0;
    w = '0;
    rd = '0;
    s_nxt = s_r;
    s_nxt.busOkPrev = busOk;

    // knx transmit picker: lowest pending point first, its answer, then write, then update read
    // runs before the sequencer so a change stored below is never cleared unsent
    if (s_r.txValid) begin
      if (knxTxReady) begin
        s_nxt.txValid = 1'b0;
      end
    end else begin
      for (int i = 0; i < NPTS; i++) begin
        if (!found && busOk && s_r.cfg[i].active
            && (s_r.rdAns[i] || s_r.txPend[i] || s_r.updPend[i])) begin
          found = 1'b1;
          s_nxt.txValid = 1'b1;
          s_nxt.txTel.group = s_r.grp[i];
          s_nxt.txTel.data = s_r.val[i];
          s_nxt.txTel.datapointTypeSel = s_r.cfg[i].datapointTypeSel;
          if (s_r.rdAns[i]) begin
            s_nxt.txTel.kind = TEL_RESP;
            s_nxt.rdAns[i] = 1'b0;
          end else if (s_r.txPend[i]) begin
            s_nxt.txTel.kind = TEL_WRITE;
            s_nxt.txPend[i] = 1'b0;
          end else begin
            s_nxt.txTel.kind = TEL_READ;
            s_nxt.updPend[i] = 1'b0;
            s_nxt.updWait[i] = 1'b1;
          end
        end
      end
    end

    // modbus side sequencer
    // device initiates all
    unique case (s_r.mbSt)
      MB_IDLE: begin
        if (wrAny) begin
          s_nxt.req.slave = s_r.cfg[wrIdx].slave;
          s_nxt.req.pidx = wrIdx;
          s_nxt.req.write = 1'b1;
          s_nxt.req.data = wrValOut;
          s_nxt.wrPend[wrIdx] = 1'b0;
          s_nxt.mbSt = MB_REQ;
        end else begin
          s_nxt.pollIdx = s_r.pollIdx + PIDX_W'(1);
          if (s_r.cfg[s_r.pollIdx].active && busOk) begin
            s_nxt.req.slave = s_r.cfg[s_r.pollIdx].slave;
            s_nxt.req.pidx = s_r.pollIdx;
            s_nxt.req.write = 1'b0;
            s_nxt.req.data = 16'h0000;
            s_nxt.mbSt = MB_REQ;
          end
        end
      end
      MB_REQ: begin
        if (mbReqReady) begin
          s_nxt.mbSt = MB_WAIT;
        end
      end
      MB_WAIT: begin
        if (mbRspValid) begin
          s_nxt.mbSt = MB_IDLE;
          pi = s_r.req.pidx;
          sIdx = s_r.req.slave - 8'h01;
          if (s_r.req.slave != 8'h00 && s_r.req.slave <= SLV_MAX) begin
            s_nxt.slvErr[sIdx] = mbRsp.timeout;
          end
          if (!mbRsp.timeout && !s_r.req.write && rspData != s_r.val[pi]) begin
            s_nxt.val[pi] = rspData;
            if (s_r.cfg[pi].tx) begin
              s_nxt.txPend[pi] = 1'b1;
            end
          end
        end
      end
      default: s_nxt.mbSt = MB_IDLE;
    endcase

    // start-up and bus recovery both show as a rising health level
    if (busOk && !s_r.busOkPrev) begin
      for (int i = 0; i < NPTS; i++) begin
        if (s_r.cfg[i].active) begin
          if (s_r.cfg[i].tx) begin
            s_nxt.txPend[i] = 1'b1;
          end
          if (s_r.cfg[i].upd) begin
            s_nxt.updPend[i] = 1'b1;
          end
        end
      end
    end

    // received telegrams after picker, sequencer and recovery, so a new event beats a same-cycle clear
    if (knxRxValid) begin
      for (int i = 0; i < NPTS; i++) begin
        unique case (knxRx.kind)
          TEL_WRITE: begin
            if ((hitG[i] && s_r.cfg[i].wr) || hitL[i]) begin
              s_nxt.val[i] = knxRx.data;
              s_nxt.wrPend[i] = 1'b1;
            end
          end
          TEL_READ: begin
            if (hitG[i] && s_r.cfg[i].rd) begin
              s_nxt.rdAns[i] = 1'b1;
            end
          end
          TEL_RESP: begin
            if (hitG[i] && s_r.updWait[i]) begin
              s_nxt.val[i] = knxRx.data;
              s_nxt.wrPend[i] = 1'b1;
              s_nxt.updWait[i] = 1'b0;
            end
          end
          default: ;
        endcase
      end
    end

    // wishbone: one wait cycle, ack for one cycle, unmapped reads zero except the aliased upper half of the point page
    s_nxt.ack = wbCyc && wbStb && !s_r.ack;
    pi = wbAdr[6:4];
    if (wbAdr[11:8] == PT_PAGE) begin
      unique case (wbAdr[3:2])
        PT_CFG: rd = 32'(s_r.cfg[pi]);
        PT_GRP: rd = {s_r.lsn[pi], s_r.grp[pi]};
        PT_VAL: rd = {16'h0000, s_r.val[pi]};
        PT_FLG: rd = {27'h000_0000, s_r.updWait[pi], s_r.updPend[pi], s_r.txPend[pi],
                      s_r.rdAns[pi], s_r.wrPend[pi]};
        default: rd = '0;
      endcase
    end else if (wbAdr[11:8] == ERR_PAGE) begin
      rd = 32'({2'b00, s_r.slvErr} >> {wbAdr[7:2], 5'h00});
    end else if (wbAdr == CTRL_OFS) begin
      rd = 32'(s_r.ser);
    end else if (wbAdr == STAT_OFS) begin
      rd = {28'h000_0000, s_r.txValid, s_r.mbSt, busOk};
    end
    if (s_nxt.ack) begin
      s_nxt.rdat = rd;
    end
    if (s_nxt.ack && wbWe) begin
      w = mrg(rd, wbDatW, wbSel);
      if (wbAdr[11:8] == PT_PAGE) begin
        unique case (wbAdr[3:2])
          PT_CFG: s_nxt.cfg[pi] = w[16:0];
          PT_GRP: begin
            s_nxt.grp[pi] = w[15:0];
            s_nxt.lsn[pi] = w[31:16];
          end
          PT_VAL: s_nxt.val[pi] = w[15:0];
          default: ;
        endcase
      end else if (wbAdr == CTRL_OFS) begin
        s_nxt.ser = w[24:0];
      end
    end
  end

  // single state register, frozen while ce is low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
      s_r.ser <= SER_RST;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign wbDatR = s_r.rdat;
  assign wbAck = s_r.ack;
  assign knxTxValid = s_r.txValid;
  assign knxTx = s_r.txTel;
  assign mbReqValid = (s_r.mbSt == MB_REQ);
  assign mbReq = s_r.req;
  assign serCfg = s_r.ser;
endmodule // knx_modbus_point_sync

// file: test/kps_assertions.sv
// port-level protocol checks for the point synchroniser
`timescale 1ns/100ps
module kps_assertions
  import kps_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [11:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [31:0] wbDatW,
  input wire logic [31:0] wbDatR,
  input wire logic wbAck,
  input wire logic knxBusOk,
  input wire logic knxTxValid,
  input wire logic knxTxReady,
  input wire knx_tel_t knxTx,
  input wire logic mbReqValid,
  input wire logic mbReqReady,
  input wire mb_req_t mbReq,
  input wire ser_cfg_t serCfg
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // one wait state, then a single ack pulse
  property p_ack_lat;
    wbCyc && wbStb && !wbAck |=> wbAck;
  endproperty
  a_ack_lat: assert property (p_ack_lat)
    else $error("ack late");
  property p_ack_pulse;
    wbAck |=> !wbAck;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack too long");
  // a hole in the map, address 12'hF00, reads as zero
  property p_hole;
    wbAck && !wbWe && wbAdr == 12'hF00 |-> wbDatR == '0;
  endproperty
  a_hole: assert property (p_hole)
    else $error("hole read not zero");
  property p_ctrl;
    wbAck && wbWe && wbAdr == CTRL_OFS && wbSel == 4'hF
      |=> {7'h00, serCfg} == ($past(wbDatW) & 32'h01FF_FFFF);
  endproperty
  a_ctrl: assert property (p_ctrl)
    else $error("serial setup not taken");
  // telegram held until the sink takes it
  property p_tx_hold;
    knxTxValid && !knxTxReady |=> knxTxValid && $stable(knxTx);
  endproperty
  a_tx_hold: assert property (p_tx_hold)
    else $error("telegram dropped");
  property p_tx_gap;
    knxTxValid && knxTxReady |=> !knxTxValid;
  endproperty
  a_tx_gap: assert property (p_tx_gap)
    else $error("no gap after telegram");
  // a dead bus gets no new telegram
  property p_tx_dead;
    !knxBusOk [*3] |=> !$rose(knxTxValid);
  endproperty
  a_tx_dead: assert property (p_tx_dead)
    else $error("telegram while bus down");
  property p_req_hold;
    mbReqValid && !mbReqReady |=> mbReqValid && $stable(mbReq);
  endproperty
  a_req_hold: assert property (p_req_hold)
    else $error("request changed");
  // accepted request is followed by two cycles without a request
  property p_req_wait;
    mbReqValid && mbReqReady |=> !mbReqValid [*2];
  endproperty
  a_req_wait: assert property (p_req_wait)
    else $error("request before answer");
  property p_req_slave;
    mbReqValid |-> mbReq.slave != 8'h00 && mbReq.slave <= SLV_MAX;
  endproperty
  a_req_slave: assert property (p_req_slave)
    else $error("bad slave address");
endmodule // kps_assertions

// file: test/kps_mb_slave.sv
// modbus slave stand-in on the master request port
`timescale 1ns/100ps
module kps_mb_slave
  import kps_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic slow,
  input wire logic silent,
  input wire logic [15:0] rdVal,
  input wire logic mbReqValid,
  input wire mb_req_t mbReq,
  output logic mbReqReady,
  output logic mbRspValid,
  output mb_rsp_t mbRsp,
  output mb_req_t lastWr,
  output int wrCnt
);
  logic [1:0] dly;
  logic busy;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mbReqReady <= 1'b0;
      mbRspValid <= 1'b0;
      mbRsp <= '0;
      lastWr <= '0;
      wrCnt <= 0;
      dly <= 2'h0;
      busy <= 1'b0;
    end else begin
      mbReqReady <= 1'b0;
      mbRspValid <= 1'b0;
      // toggling so a stale answer never looks valid
      mbRsp <= ~mbRsp;
      if (busy) begin
        dly <= dly + 2'h1;
        if (dly == 2'h2) begin
          busy <= 1'b0;
          dly <= 2'h0;
          mbRspValid <= 1'b1;
          mbRsp <= '{rdVal, silent};
        end
      end else if (mbReqValid && mbReqReady) begin
        busy <= 1'b1;
        if (mbReq.write) begin
          lastWr <= mbReq;
          wrCnt <= wrCnt + 1;
        end
      end else if (mbReqValid) begin
        dly <= dly + 2'h1;
        if (!slow || dly == 2'h2) begin
          mbReqReady <= 1'b1;
          dly <= 2'h0;
        end
      end
    end
  end
endmodule // kps_mb_slave

// file: test/test_knx_modbus_point_sync.sv
// self-checking bench for the point synchroniser
`timescale 1ns/100ps
module test_knx_modbus_point_sync
  import kps_pkg::*;
;
  logic clk, rst_n, ce, wbCyc, wbStb, wbWe, wbAck, knxBusOk, knxRxValid;
  logic knxTxValid, knxTxReady, mbReqValid, mbReqReady, mbRspValid, slow, silent;
  logic [11:0] wbAdr;
  logic [3:0] wbSel;
  logic [31:0] wbDatW, wbDatR, rdat;
  logic [15:0] rdVal;
  knx_tel_t knxRx, knxTx, txE;
  knx_tel_t txq[$];
  mb_req_t mbReq, lastWr;
  mb_rsp_t mbRsp;
  ser_cfg_t serCfg;
  int wrCnt, err_count, cmp_count;
  knx_modbus_point_sync dut (.clk(clk), .rst_n(rst_n), .ce(ce), .wbCyc(wbCyc),
    .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatW(wbDatW),
    .wbDatR(wbDatR), .wbAck(wbAck), .knxBusOk(knxBusOk), .knxRxValid(knxRxValid),
    .knxRx(knxRx), .knxTxValid(knxTxValid), .knxTxReady(knxTxReady), .knxTx(knxTx),
    .mbReqValid(mbReqValid), .mbReqReady(mbReqReady), .mbReq(mbReq),
    .mbRspValid(mbRspValid), .mbRsp(mbRsp), .serCfg(serCfg));
  kps_mb_slave far (.clk(clk), .rst_n(rst_n), .slow(slow), .silent(silent),
    .rdVal(rdVal), .mbReqValid(mbReqValid), .mbReq(mbReq), .mbReqReady(mbReqReady),
    .mbRspValid(mbRspValid), .mbRsp(mbRsp), .lastWr(lastWr), .wrCnt(wrCnt));
  // 100 ns clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // knx sink stalls one cycle per telegram, keeps what it takes
  always @(posedge clk) begin
    knxTxReady <= knxTxValid && !knxTxReady;
    if (knxTxValid && knxTxReady) txq.push_back(knxTx);
  end
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      err_count++;
      $display("unexpected at %0t seen %h exp %h", $time, s, e);
    end
  endtask
  task automatic gap(input int n);
    repeat (n) @(posedge clk);
  endtask
  // one classic cycle; the watchdog bounds the wait for ack
  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= w;
    wbAdr <= a;
    wbDatW <= d;
    do @(posedge clk); while (wbAck !== 1'b1);
    rdat = wbDatR;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    wb(1'b0, a, '0);
    chk(rdat, e);
  endtask
  task automatic tel(input logic [1:0] k, input logic [15:0] g, input logic [15:0] d);
    knxRx <= '{k, g, d, 4'h0};
    knxRxValid <= 1'b1;
    @(posedge clk);
    knxRxValid <= 1'b0;
    @(posedge clk);
  endtask
  // counts modbus writes caused by one telegram
  task automatic wrTel(input logic [1:0] k, input logic [15:0] g, input logic [15:0] d,
                       input logic [31:0] n);
    int c;
    c = wrCnt;
    tel(k, g, d);
    gap(60);
    chk(32'(wrCnt - c), n);
  endtask
  task automatic expTx(input logic [1:0] k, input logic [15:0] g, input logic e);
    logic f;
    f = 1'b0;
    gap(300);
    foreach (txq[i]) begin
      if (txq[i].kind === k && txq[i].group === g) begin
        f = 1'b1;
        txE = txq[i];
      end
    end
    chk(32'(f), 32'(e));
  endtask
  task automatic t_regs;
    rd(CTRL_OFS, {7'h00, SER_RST});
    rd(STAT_OFS, '0);
    wb(1'b1, 12'hF00, 32'hFFFF_FFFF);
    rd(12'hF00, '0);
    wb(1'b1, CTRL_OFS, 32'h00F5_00A3);
    rd(CTRL_OFS, 32'h00F5_00A3);
    wbSel <= 4'h1;
    wb(1'b1, CTRL_OFS, 32'hFFFF_FF11);
    wbSel <= 4'hF;
    rd(CTRL_OFS, 32'h00F5_0011);
    wb(1'b1, CTRL_OFS, {7'h00, SER_RST});
    rd(12'h200, '0);
    $display("t_regs done");
  endtask
  task automatic t_cfg;
    wb(1'b1, 12'h100, 32'h0000_0A6F);
    wb(1'b1, 12'h104, 32'h0B02_0A01);
    wb(1'b1, 12'h110, 32'h0000_0C11);
    wb(1'b1, 12'h114, 32'h0000_0A02);
    wb(1'b1, 12'h120, 32'h0000_0E1E);
    wb(1'b1, 12'h124, 32'h0000_0A03);
    rd(12'h100, 32'h0000_0A6F);
    rd(12'h104, 32'h0B02_0A01);
    $display("t_cfg done");
  endtask
  task automatic t_recover;
    knxBusOk <= 1'b0;
    gap(10);
    txq.delete();
    knxBusOk <= 1'b1;
    expTx(TEL_READ, 16'h0A02, 1'b1);
    expTx(TEL_WRITE, 16'h0A01, 1'b1);
    expTx(TEL_READ, 16'h0A03, 1'b0);
    wrTel(TEL_RESP, 16'h0A02, 16'h7777, 1);
    chk({4'h0, lastWr}, {4'h0, 8'h06, 3'h1, 1'b1, 16'h7777});
    wrTel(TEL_RESP, 16'h0A02, 16'h7777, 0);
    $display("t_recover done");
  endtask
  task automatic t_knx;
    wrTel(TEL_WRITE, 16'h0A01, 16'h1234, 1);
    chk({4'h0, lastWr}, {4'h0, 8'h05, 3'h0, 1'b1, 16'h1234});
    wrTel(TEL_WRITE, 16'h0B02, 16'h4321, 1);
    wrTel(TEL_WRITE, 16'h0A02, 16'h1111, 0);
    wrTel(TEL_WRITE, 16'h0A03, 16'h2222, 0);
    $display("t_knx done");
  endtask
  task automatic t_read;
    txq.delete();
    tel(TEL_READ, 16'h0A01, 16'h0000);
    expTx(TEL_RESP, 16'h0A01, 1'b1);
    chk(32'(txE.data), 32'h0000_0055);
    chk(32'(txE.datapointTypeSel), 32'h0000_0003);
    tel(TEL_READ, 16'h0A02, 16'h0000);
    expTx(TEL_RESP, 16'h0A02, 1'b0);
    $display("t_read done");
  endtask
  task automatic t_poll;
    rd(12'h108, 32'h0000_0055);
    wb(1'b1, CTRL_OFS, 32'h0108_0411);
    rdVal <= 16'h3412;
    txq.delete();
    expTx(TEL_WRITE, 16'h0A01, 1'b1);
    chk(32'(txE.data), 32'h0000_1234);
    rd(12'h108, 32'h0000_1234);
    $display("t_poll done");
  endtask
  task automatic t_tmo;
    silent <= 1'b1;
    slow <= 1'b1;
    gap(200);
    rd(12'h200, 32'h0000_0030);
    silent <= 1'b0;
    gap(200);
    rd(12'h200, '0);
    slow <= 1'b0;
    $display("t_tmo done");
  endtask
  // watchdog sized well above the whole sequence
  initial begin
    gap(40000);
    err_count++;
    report_and_stop();
  end
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    wbCyc = 1'b0;
    wbStb = 1'b0;
    wbWe = 1'b0;
    wbAdr = '0;
    wbSel = 4'hF;
    wbDatW = '0;
    knxBusOk = 1'b0;
    knxRxValid = 1'b0;
    knxRx = '0;
    slow = 1'b0;
    silent = 1'b0;
    rdVal = 16'h0055;
    err_count = 0;
    cmp_count = 0;
    gap(8);
    rst_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_cfg();
    t_recover();
    t_knx();
    t_read();
    t_poll();
    t_tmo();
    t_recover();
    report_and_stop();
  end
endmodule // test_knx_modbus_point_sync
bind knx_modbus_point_sync kps_assertions chk_i (.clk(clk), .rst_n(rst_n), .wbCyc(wbCyc),
  .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatW(wbDatW),
  .wbDatR(wbDatR), .wbAck(wbAck), .knxBusOk(knxBusOk), .knxTxValid(knxTxValid),
  .knxTxReady(knxTxReady), .knxTx(knxTx), .mbReqValid(mbReqValid),
  .mbReqReady(mbReqReady), .mbReq(mbReq), .serCfg(serCfg));
